// ---- common/vdla_consts.svh ----
// register offsets, field positions and reset values for the line address block
`ifndef VDLA_CONSTS_SVH
`define VDLA_CONSTS_SVH
`define VDLA_ADDR_W 8
`define VDLA_DATA_W 8
`define VDLA_OFS_LCD_LO 8'h46
`define VDLA_OFS_LCD_HI 8'h47
`define VDLA_OFS_CRT_LO 8'h66
`define VDLA_OFS_CRT_HI 8'h67
`define VDLA_OFS_LCD_START0 8'hC0
`define VDLA_OFS_LCD_START1 8'hC1
`define VDLA_OFS_LCD_START2 8'hC2
`define VDLA_OFS_CRT_START0 8'hC4
`define VDLA_OFS_CRT_START1 8'hC5
`define VDLA_OFS_CRT_START2 8'hC6
`define VDLA_OFS_LCD_PAN 8'hC8
`define VDLA_OFS_CRT_PAN 8'hC9
`define VDLA_OFS_BPP 8'hCA
`define VDLA_OFS_STATUS 8'hCB
`define VDLA_STRIDE_W 11
`define VDLA_HI_BITS 3
`define VDLA_ADDR_WORD_W 20
`define VDLA_BUF_BYTES 21'd1310720
`define VDLA_BUF_WORDS 20'd655360
`define VDLA_START_HI_BITS 4
`define VDLA_PAN_W 2
`define VDLA_STRIDE_RST 11'h000
`define VDLA_START_RST 20'h00000
`define VDLA_PAN_RST 2'h0
`define VDLA_BPP_RST 2'h0
`define VDLA_BPP_4 2'h0
`define VDLA_BPP_8 2'h1
`define VDLA_BPP_16 2'h2
`define VDLA_PPW_4 5'h04
`define VDLA_PPW_8 5'h02
`define VDLA_PPW_16 5'h01
`endif

// ---- common/vdla_pkg.sv ----
// types shared by the line address block
package vdla_pkg;
  typedef enum logic [1:0] {
    VDLA_IDLE = 2'b00,
    VDLA_FIRST = 2'b01,
    VDLA_RUN = 2'b11
  } vdla_phase_e;

  // state of one pipe's line address walker
  typedef struct packed {
    vdla_phase_e phase;
    logic [19:0] line_addr;
    logic [1:0] pan;
    logic valid;
    logic wrap;
  } vdla_pipe_s;

  // whole block state
  typedef struct packed {
    logic [10:0] lcd_stride;
    logic [10:0] crt_stride;
    logic [19:0] lcd_start;
    logic [19:0] crt_start;
    logic [1:0] lcd_pan_reg;
    logic [1:0] crt_pan_reg;
    logic [1:0] bpp;
    logic [7:0] rdata;
    vdla_pipe_s lcd;
    vdla_pipe_s crt;
  } vdla_state_s;
endpackage

// ---- logic/vdla_line_addr.sv ----
// line start address generator for the panel and crt/tv pipes
`timescale 1ns/1ps
`include "vdla_consts.svh"
//
// Summary of operation
// - the panel stride is 11 bits, low byte register plus three bits of the high register.
// - the crt/tv stride is a separate 11-bit value built the same way.
// - each stride takes any value up to its 11-bit maximum of 2047 words.
// - each panel line starts exactly stride words after the previous line start.
// - each crt/tv line starts exactly the crt/tv stride in words after the previous one.
// - a word holds four pixels at 4 bpp and one pixel at 16 bpp.
// - at 8 bpp a byte is one pixel, so a word holds two pixels.
// - a word is two bytes, so a line takes twice the stride in bytes.
// - stepped line addresses wrap inside the 1,310,720 byte display buffer; the start address is not range checked.
// - the first line address is the start address, captured once at each frame start.
// - a start address of zero is the first word of the buffer.
// - pixel pan is captured every line once a frame has started, start address only at frame start.

module vdla_line_addr
  import vdla_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // panel timing strobes
  input wire logic lcd_frame_start,
  input wire logic lcd_line_start,
  // crt/tv timing strobes
  input wire logic crt_frame_start,
  input wire logic crt_line_start,
  // panel line address out
  output logic [19:0] lcd_line_addr,
  output logic [1:0] lcd_line_pan,
  output logic lcd_line_valid,
  // crt/tv line address out
  output logic [19:0] crt_line_addr,
  output logic [1:0] crt_line_pan,
  output logic crt_line_valid,
  // pixels per buffer word at the current depth
  output logic [4:0] word_pixel_count
);

  vdla_state_s st_ff;
  vdla_state_s nxt_st;
  logic [4:0] ppw_ff;
  logic [4:0] nxt_ppw;

  // ------------------------------------------------------------------
  // one pipe step
  // ------------------------------------------------------------------
  // the accumulator adds the stride per line instead of multiplying,
  // so one adder per pipe serves any line count
  function automatic vdla_pipe_s step_pipe(input vdla_pipe_s cur, input logic frame,
      input logic line, input logic [19:0] start, input logic [10:0] stride,
      input logic [1:0] pan);
    vdla_pipe_s nx;
    logic [20:0] sum;
    nx = cur;
    nx.valid = 1'b0;
    sum = 21'({1'b0, cur.line_addr}) + 21'(stride);
    if (frame) begin
      nx.phase = VDLA_FIRST;
      nx.line_addr = start;
      nx.wrap = 1'b0;
    end else if (line) begin
      nx.pan = pan;
      nx.valid = 1'b1;
      unique case (cur.phase)
        VDLA_IDLE: begin
          // no frame seen yet: pan stays put so nothing moves without a valid line
          nx.pan = cur.pan;
          nx.valid = 1'b0;
        end
        VDLA_FIRST: begin
          nx.phase = VDLA_RUN;
        end
        VDLA_RUN: begin
          // wrap at buffer end so a stepped address never leaves the buffer
          if (sum >= 21'(`VDLA_BUF_WORDS)) begin
            nx.line_addr = 20'(sum - 21'(`VDLA_BUF_WORDS));
            nx.wrap = 1'b1;
          end else begin
            nx.line_addr = sum[19:0];
          end
        end
        default: begin
          nx.phase = VDLA_IDLE;
          nx.valid = 1'b0;
        end
      endcase
    end
    return nx;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    // register writes; high bits above the stride read back zero
    if (reg_wr) begin
      unique case (reg_addr)
        `VDLA_OFS_LCD_LO: nxt_st.lcd_stride[7:0] = reg_wdata;
        `VDLA_OFS_LCD_HI: nxt_st.lcd_stride[10:8] = reg_wdata[2:0];
        `VDLA_OFS_CRT_LO: nxt_st.crt_stride[7:0] = reg_wdata;
        `VDLA_OFS_CRT_HI: nxt_st.crt_stride[10:8] = reg_wdata[2:0];
        `VDLA_OFS_LCD_START0: nxt_st.lcd_start[7:0] = reg_wdata;
        `VDLA_OFS_LCD_START1: nxt_st.lcd_start[15:8] = reg_wdata;
        `VDLA_OFS_LCD_START2: nxt_st.lcd_start[19:16] = reg_wdata[3:0];
        `VDLA_OFS_CRT_START0: nxt_st.crt_start[7:0] = reg_wdata;
        `VDLA_OFS_CRT_START1: nxt_st.crt_start[15:8] = reg_wdata;
        `VDLA_OFS_CRT_START2: nxt_st.crt_start[19:16] = reg_wdata[3:0];
        `VDLA_OFS_LCD_PAN: nxt_st.lcd_pan_reg = reg_wdata[1:0];
        `VDLA_OFS_CRT_PAN: nxt_st.crt_pan_reg = reg_wdata[1:0];
        `VDLA_OFS_BPP: nxt_st.bpp = reg_wdata[1:0];
        default: ;
      endcase
    end
    // register reads, data one cycle later; unmapped reads give zero
    if (reg_rd) begin
      unique case (reg_addr)
        `VDLA_OFS_LCD_LO: nxt_st.rdata = st_ff.lcd_stride[7:0];
        `VDLA_OFS_LCD_HI: nxt_st.rdata = {5'h00, st_ff.lcd_stride[10:8]};
        `VDLA_OFS_CRT_LO: nxt_st.rdata = st_ff.crt_stride[7:0];
        `VDLA_OFS_CRT_HI: nxt_st.rdata = {5'h00, st_ff.crt_stride[10:8]};
        `VDLA_OFS_LCD_START0: nxt_st.rdata = st_ff.lcd_start[7:0];
        `VDLA_OFS_LCD_START1: nxt_st.rdata = st_ff.lcd_start[15:8];
        `VDLA_OFS_LCD_START2: nxt_st.rdata = {4'h0, st_ff.lcd_start[19:16]};
        `VDLA_OFS_CRT_START0: nxt_st.rdata = st_ff.crt_start[7:0];
        `VDLA_OFS_CRT_START1: nxt_st.rdata = st_ff.crt_start[15:8];
        `VDLA_OFS_CRT_START2: nxt_st.rdata = {4'h0, st_ff.crt_start[19:16]};
        `VDLA_OFS_LCD_PAN: nxt_st.rdata = {6'h00, st_ff.lcd_pan_reg};
        `VDLA_OFS_CRT_PAN: nxt_st.rdata = {6'h00, st_ff.crt_pan_reg};
        `VDLA_OFS_BPP: nxt_st.rdata = {6'h00, st_ff.bpp};
        `VDLA_OFS_STATUS: nxt_st.rdata = {4'h0, st_ff.crt.wrap, st_ff.lcd.wrap,
                                          st_ff.crt.phase == VDLA_RUN,
                                          st_ff.lcd.phase == VDLA_RUN};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    // pipes use the registers as they stood before this cycle's write
    nxt_st.lcd = step_pipe(st_ff.lcd, lcd_frame_start, lcd_line_start, st_ff.lcd_start,
                           st_ff.lcd_stride, st_ff.lcd_pan_reg);
    nxt_st.crt = step_pipe(st_ff.crt, crt_frame_start, crt_line_start, st_ff.crt_start,
                           st_ff.crt_stride, st_ff.crt_pan_reg);
  end

  // pixels per word from the colour depth; reserved code treated as 16 bpp
  always_comb begin
    unique case (nxt_st.bpp)
      `VDLA_BPP_4: nxt_ppw = `VDLA_PPW_4;
      `VDLA_BPP_8: nxt_ppw = `VDLA_PPW_8;
      default: nxt_ppw = `VDLA_PPW_16;
    endcase
  end

  // ------------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      ppw_ff <= `VDLA_PPW_4;
    end else begin
      st_ff <= nxt_st;
      ppw_ff <= nxt_ppw;
    end
  end

  // outputs straight from flip-flops; byte address is twice the word address
  assign reg_rdata = st_ff.rdata;
  assign lcd_line_addr = st_ff.lcd.line_addr;
  assign lcd_line_pan = st_ff.lcd.pan;
  assign lcd_line_valid = st_ff.lcd.valid;
  assign crt_line_addr = st_ff.crt.line_addr;
  assign crt_line_pan = st_ff.crt.pan;
  assign crt_line_valid = st_ff.crt.valid;
  assign word_pixel_count = ppw_ff;

endmodule // vdla_line_addr

// ---- test/vdla_line_addr_props.sv ----
// port checks for the line address block
`timescale 1ns/1ps
module vdla_line_addr_props(
  // clock and reset
  input wire logic sys_clk, sys_rst,
  // register port
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic reg_wr, reg_rd,
  // pipes
  input wire logic lcd_frame_start, lcd_line_start, crt_frame_start, crt_line_start,
  input wire logic [19:0] lcd_line_addr, crt_line_addr,
  input wire logic [1:0] lcd_line_pan, crt_line_pan,
  input wire logic lcd_line_valid, crt_line_valid,
  input wire logic [4:0] word_pixel_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_lcd_valid_cause: assert property (lcd_line_valid |-> $past(lcd_line_start))
    else $error("lcd valid without line");
  chk_crt_valid_cause: assert property (crt_line_valid |-> $past(crt_line_start))
    else $error("crt valid without line");
  chk_valid_one_cycle: assert property (lcd_line_valid |=> !lcd_line_valid)
    else $error("lcd valid too long");
  chk_lcd_addr_hold:
    assert property (!lcd_line_valid && !$past(lcd_frame_start) |-> $stable(lcd_line_addr))
    else $error("lcd addr moved");
  chk_crt_pan_hold:
    assert property (!crt_line_valid && !$past(crt_frame_start) |-> $stable(crt_line_pan))
    else $error("crt pan moved");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  chk_hi_read_mask:
    assert property ($past(reg_rd) && $past(reg_addr[4:0]) == 5'h07 |-> reg_rdata[7:3] == 5'h00)
    else $error("stride high bits set");
  chk_addr_in_buf:
    assert property (lcd_line_addr < 20'd655360 && crt_line_addr < 20'd655360)
    else $error("line addr past buffer");
  chk_ppw_legal: assert property (word_pixel_count inside {5'h04, 5'h02, 5'h01})
    else $error("bad pixels per word");
endmodule // vdla_line_addr_props

// ---- test/vdla_scan_src.sv ----
// timing source standing in for one refresh path
`timescale 1ns/1ps
module vdla_scan_src(
  // clock
  input wire logic sys_clk,
  // strobes
  output logic frame_start = 1'b0,
  output logic line_start = 1'b0
);
  // optional frame pulse, then n lines; gap of one or more idle cycles
  task automatic run(input int n, input int gap, input bit fr);
    if (fr) begin
      @(posedge sys_clk) frame_start <= 1'b1;
      @(posedge sys_clk) frame_start <= 1'b0;
    end
    repeat (n) begin
      repeat (gap) @(posedge sys_clk);
      line_start <= 1'b1;
      @(posedge sys_clk) line_start <= 1'b0;
    end
  endtask
endmodule // vdla_scan_src

// ---- test/tb_top.sv ----
// self-checking bench for the line address block
`timescale 1ns/1ps
`include "vdla_consts.svh"
bind vdla_line_addr vdla_line_addr_props chk_u(.*);
module tb_top;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, got, seed = 8'h38;
  logic lcd_frame_start, lcd_line_start, crt_frame_start, crt_line_start;
  logic [19:0] lcd_line_addr, crt_line_addr;
  logic [1:0] lcd_line_pan, crt_line_pan;
  logic lcd_line_valid, crt_line_valid;
  logic [4:0] word_pixel_count;
  logic [7:0] rz[5] = '{8'h46, 8'h47, 8'h66, 8'h67, 8'h10};
  int err_total = 0, total_checks = 0, cyc = 0, st[2], sd[2], pn[2], ex[2], nv[2] = '{0, 0};
  bit ar[2];
  vdla_line_addr dut_u(.*);
  vdla_scan_src lcd_src(.sys_clk, .frame_start(lcd_frame_start), .line_start(lcd_line_start));
  vdla_scan_src crt_src(.sys_clk, .frame_start(crt_frame_start), .line_start(crt_line_start));
  always #5 sys_clk = ~sys_clk;
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  // reference pipe: start on frame, add stride per line, wrap at buffer end
  task automatic step(input int p, input logic fs, v, input logic [19:0] a, input logic [1:0] q);
    if (v) begin
      chk("armed", 1, 20'(ar[p]));
      chk("line_addr", ex[p], a);
      chk("line_pan", pn[p], q);
      ex[p] = (ex[p] + sd[p]) % 655360;
      nv[p]++;
    end
    if (fs) begin
      ex[p] = st[p];
      ar[p] = 1;
    end
  endtask
  // stride, start and pan of one pipe; stride kept wide enough for the panel
  task automatic cfg(input int p, input int s, input int d, input int q);
    wr(8'(8'h46 + 32 * p), d[7:0]);
    wr(8'(8'h47 + 32 * p), d[15:8]);
    for (int k = 0; k < 3; k++) wr(8'(`VDLA_OFS_LCD_START0 + 4 * p + k), 8'(s >> (8 * k)));
    wr(8'(`VDLA_OFS_LCD_PAN + p), q[7:0]);
    st[p] = s;
    sd[p] = d;
    pn[p] = q % 4;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (sys_rst) ar = '{0, 0};
    else begin
      step(0, lcd_frame_start, lcd_line_valid, lcd_line_addr, lcd_line_pan);
      step(1, crt_frame_start, crt_line_valid, crt_line_addr, crt_line_pan);
    end
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    lcd_src.run(2, 1, 0);
    foreach (rz[i]) begin
      rd(rz[i]);
      chk("reset_read", 0, got);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h46 + 32 * (i % 2)), i ? seed : 8'hFF);
      wr(8'(8'h47 + 32 * (i % 2)), i ? lf(seed) : 8'hFF);
      rd(8'(8'h46 + 32 * (i % 2)));
      chk("stride_lo", i ? seed : 8'hFF, got);
      rd(8'(8'h47 + 32 * (i % 2)));
      chk("stride_hi", i ? lf(seed) & 8'h07 : 8'h07, got);
      seed = lf(lf(seed));
    end
    for (int i = 0; i < 4; i++) begin
      wr(`VDLA_OFS_BPP, 8'(i));
      repeat (2) @(posedge sys_clk);
      #1 chk("word_pixels", i == 0 ? 4 : i == 1 ? 2 : 1, 20'(word_pixel_count));
    end
    // short frames; the second lcd frame runs past the buffer end and wraps
    for (int i = 0; i < 3; i++) begin
      cfg(0, i == 0 ? 0 : i == 1 ? 652360 : seed * 4, i == 0 ? 400 : i == 1 ? 2047 : 200 + seed, i);
      cfg(1, 1000 * i + seed, 100 * (i + 1) + seed, 3 - i);
      fork
        lcd_src.run(4, 1 + seed % 3, 1);
        crt_src.run(5, 2, 1);
      join
      repeat (3) @(posedge sys_clk);
      seed = lf(seed);
    end
    // every line after a frame must have produced exactly one valid pulse
    chk("lcd_lines", 12, 20'(nv[0]));
    chk("crt_lines", 15, 20'(nv[1]));
    // both pipes running, last lcd frame started low so no wrap is pending
    rd(`VDLA_OFS_STATUS);
    chk("status", 20'h3, got);
    summarize();
  end
endmodule // tb_top
